// ---- src/rsurm_pkg.sv ----
// constants and carrier types of the rate sensor user register map
package rsurm_pkg;

  // byte addresses of the even (low) byte of each register
  localparam logic [6:0] ADDR_NV_WRITE_COUNT = 7'h00;
  localparam logic [6:0] ADDR_SUPPLY = 7'h02;
  localparam logic [6:0] ADDR_RATE = 7'h04;
  localparam logic [6:0] ADDR_RATE_EXT = 7'h06;
  localparam logic [6:0] ADDR_AUX = 7'h0A;
  localparam logic [6:0] ADDR_TEMP = 7'h0C;
  localparam logic [6:0] ADDR_SLEEP = 7'h3A;
  localparam logic [6:0] ADDR_ERROR = 7'h3C;
  localparam logic [6:0] ADDR_COMMAND = 7'h3E;
  localparam logic [6:0] ADDR_LOT1 = 7'h52;
  localparam logic [6:0] ADDR_LOT2 = 7'h54;
  localparam logic [6:0] ADDR_PART = 7'h56;
  localparam logic [6:0] ADDR_SERIAL = 7'h58;

  // read/write words: 0 bias, 1 gain, 2..3 thresholds, 4..5 periods,
  // 6 alarm config, 7 analog out, 8 dio, 9 misc, 10 decimation, 11 range
  localparam int CFG_N = 12;
  localparam logic [CFG_N-1:0][6:0] CFG_OFFS = {
    7'h38, 7'h36, 7'h34, 7'h32, 7'h30, 7'h28,
    7'h26, 7'h24, 7'h22, 7'h20, 7'h16, 7'h14};
  localparam logic [CFG_N-1:0][15:0] CFG_RESET = {
    16'h0401, 16'h0000, 16'h0006, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0800, 16'h0000};
  // words with a nonvolatile copy (analog out and dio have none)
  localparam logic [CFG_N-1:0] CFG_NV_MASK = 12'hE7F;
  localparam logic [3:0] CFG_DEC_IDX = 4'hA;

  // serial frame layout
  localparam int FRAME_RW_BIT = 15;
  localparam int FRAME_ADDR_MSB = 14;
  localparam int FRAME_ADDR_LSB = 8;
  localparam logic [4:0] FRAME_LAST = 5'h0F;

  // output word flag positions and unread flag indices
  localparam int FRESH_BIT = 15;
  localparam int FAULT_BIT = 14;
  localparam int UNREAD_N = 4;
  localparam int U_SUPPLY = 0;
  localparam int U_RATE = 1;
  localparam int U_AUX = 2;
  localparam int U_TEMP = 3;
  localparam logic [3:0] UNREAD_ALL = 4'hF;
  localparam logic [3:0] UNREAD_RESET = 4'h0;

  // arbitrary neutral identification value
  localparam logic [15:0] PART_CODE_DEFAULT = 16'h5A5A;

  typedef struct packed {
    logic [11:0] supply;
    logic [13:0] rate;
    logic [15:0] rate_ext;
    logic [11:0] aux;
    logic [11:0] temp;
  } rsurm_sample_type;

  typedef struct packed {
    logic [15:0] range_and_filter;
    logic [15:0] decimation_setting;
    logic [15:0] misc_control;
    logic [15:0] dio_line_control;
    logic [15:0] analog_out_setting;
    logic [15:0] alarm_config;
    logic [15:0] alarm2_sample_period;
    logic [15:0] alarm1_sample_period;
    logic [15:0] alarm2_threshold;
    logic [15:0] alarm1_threshold;
    logic [15:0] rate_gain_trim;
    logic [15:0] rate_bias_trim;
  } rsurm_cfg_type;

  typedef struct packed {
    logic [15:0] nv_write_count;
    logic [15:0] lot_code_first;
    logic [15:0] lot_code_second;
    logic [15:0] unit_serial;
    logic [15:0] sleep_request;
    logic [CFG_N-1:0][15:0] cfg;
  } rsurm_nv_type;

  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_m;
    logic cs_s;
    logic din_m;
    logic din_s;
    logic [15:0] rx;
    logic [4:0] cnt;
    logic [15:0] tx;
    logic resp;
    logic dout;
    logic dout_oe;
    logic restore;
    logic [CFG_N-1:0][15:0] cfg;
    logic [15:0] sleep_value;
    logic sleep_strobe;
    logic [15:0] command_value;
    logic command_strobe;
    rsurm_sample_type samp;
    logic [UNREAD_N-1:0] unread;
    logic [15:0] nv_write_count;
    logic [15:0] lot_code_first;
    logic [15:0] lot_code_second;
    logic [15:0] unit_serial;
  } rsurm_state_type;

endpackage

// ---- src/rsurm_regmap.sv ----
// serial-accessed user register bank of the rate sensor
`timescale 1ns/1ps
// Summary of operation
// - each 16-bit register spans two bytes: even address low, odd high
// - read-only write counter at 0x00, supply output at 0x02
// - read-only rate 0x04, extended rate 0x06, aux 0x0A, temperature 0x0C
// - bias trim 0x14 resets 0x0000, gain trim 0x16 resets 0x0800
// - five alarm registers 0x20 to 0x28, all reset to zero
// - analog output 0x30 and dio control 0x32 reset to zero, volatile
// - misc control at 0x34, flash backed, resets to 0x0006
// - decimation at 0x36 resets 0x0000, range/filter 0x38 resets 0x0401
// - write-only flash-backed sleep request at 0x3A
// - read-only error flag register at 0x3C, volatile
// - write-only global command register at 0x3E, volatile
// - read-only ids: lot codes 0x52 0x54, part 0x56, serial 0x58
// - output bit 15 reads one while the sample is unread
// - output bit 14 reads one while error flags are nonzero
// - rate output holds 14-bit two's complement sample in bits 13..0
// - extended rate keeps as many MSB-justified bits as decimation setting
// - temperature holds 12-bit two's complement in bits 11..0
// - supply holds unsigned 12-bit value in bits 11..0
// - flash-backed registers reload from nonvolatile copy after reset
// - read takes two frames: request, then contents in the next frame
// - output line driven only after a frame whose first bit was zero
module rsurm_regmap #(
  parameter logic [15:0] PART_CODE = rsurm_pkg::PART_CODE_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // sensor core
  input wire logic sample_load,
  input wire rsurm_pkg::rsurm_sample_type sample_in,
  input wire logic [15:0] error_flags_in,
  // nonvolatile image
  input wire rsurm_pkg::rsurm_nv_type nv_image,
  // configuration to the core
  output rsurm_pkg::rsurm_cfg_type cfg,
  output logic [15:0] sleep_value,
  output logic sleep_strobe,
  output logic [15:0] command_value,
  output logic command_strobe
);

  rsurm_pkg::rsurm_state_type state_reg;
  rsurm_pkg::rsurm_state_type state_next;

  // finds the read/write word selected by a byte address
  function automatic logic [4:0] cfg_lookup(input logic [6:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < rsurm_pkg::CFG_N; i++) begin
      if (addr[6:1] == rsurm_pkg::CFG_OFFS[i][6:1]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  // output word with fresh and fault flags on top
  function automatic logic [15:0] out_word(
    input logic fresh,
    input logic fault,
    input logic [13:0] data
  );
    return {fresh, fault, data};
  endfunction

  logic rise;
  logic fall;
  logic active;
  logic done;
  logic fault;
  logic [15:0] word;
  logic [6:0] addr;
  logic [6:0] waddr;
  logic [4:0] hit;
  logic [15:0] rd_word;
  logic [rsurm_pkg::UNREAD_N-1:0] clr;
  logic [15:0] ext_mask;

  always_comb begin
    state_next = state_reg;
    state_next.sleep_strobe = 1'b0;
    state_next.command_strobe = 1'b0;
    // two-stage synchronisers, third stage for edge finding
    state_next.sclk_m = sclk;
    state_next.sclk_s = state_reg.sclk_m;
    state_next.sclk_d = state_reg.sclk_s;
    state_next.cs_m = cs_n;
    state_next.cs_s = state_reg.cs_m;
    state_next.din_m = din;
    state_next.din_s = state_reg.din_m;
    rise = state_reg.sclk_s & ~state_reg.sclk_d;
    fall = ~state_reg.sclk_s & state_reg.sclk_d;
    active = ~state_reg.cs_s;
    word = {state_reg.rx[14:0], state_reg.din_s};
    addr = word[rsurm_pkg::FRAME_ADDR_MSB:rsurm_pkg::FRAME_ADDR_LSB];
    waddr = {addr[6:1], 1'b0};
    hit = cfg_lookup(addr);
    fault = |error_flags_in;
    done = 1'b0;
    clr = '0;
    ext_mask = ~(16'hFFFF >> state_reg.cfg[rsurm_pkg::CFG_DEC_IDX][3:0]);

    // frame receive on rising edges of the link clock
    if (!active) begin
      state_next.cnt = 5'h00;
    end else if (rise) begin
      state_next.rx = word;
      if (state_reg.cnt == rsurm_pkg::FRAME_LAST) begin
        state_next.cnt = 5'h00;
        done = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 5'h01;
      end
    end

    // answer shifts out on falling edges
    if (active && fall) begin
      state_next.dout = state_reg.tx[15];
      state_next.tx = {state_reg.tx[14:0], 1'b0};
    end
    state_next.dout_oe = active & state_reg.resp;

    // read multiplexer, unknown addresses give zero
    rd_word = 16'h0000;
    if (hit[4]) begin
      rd_word = state_reg.cfg[hit[3:0]];
    end else begin
      unique case (waddr)
        rsurm_pkg::ADDR_NV_WRITE_COUNT:
          rd_word = state_reg.nv_write_count;
        rsurm_pkg::ADDR_SUPPLY: begin
          rd_word = out_word(state_reg.unread[rsurm_pkg::U_SUPPLY], fault,
            {2'b00, state_reg.samp.supply});
          clr[rsurm_pkg::U_SUPPLY] = 1'b1;
        end
        rsurm_pkg::ADDR_RATE: begin
          rd_word = out_word(state_reg.unread[rsurm_pkg::U_RATE], fault,
            state_reg.samp.rate);
          clr[rsurm_pkg::U_RATE] = 1'b1;
        end
        rsurm_pkg::ADDR_RATE_EXT:
          rd_word = state_reg.samp.rate_ext & ext_mask;
        rsurm_pkg::ADDR_AUX: begin
          rd_word = out_word(state_reg.unread[rsurm_pkg::U_AUX], fault,
            {2'b00, state_reg.samp.aux});
          clr[rsurm_pkg::U_AUX] = 1'b1;
        end
        rsurm_pkg::ADDR_TEMP: begin
          rd_word = out_word(state_reg.unread[rsurm_pkg::U_TEMP], fault,
            {2'b00, state_reg.samp.temp});
          clr[rsurm_pkg::U_TEMP] = 1'b1;
        end
        rsurm_pkg::ADDR_ERROR: rd_word = error_flags_in;
        rsurm_pkg::ADDR_LOT1: rd_word = state_reg.lot_code_first;
        rsurm_pkg::ADDR_LOT2: rd_word = state_reg.lot_code_second;
        rsurm_pkg::ADDR_PART: rd_word = PART_CODE;
        rsurm_pkg::ADDR_SERIAL: rd_word = state_reg.unit_serial;
        default: rd_word = 16'h0000;
      endcase
    end

    // completed frame: write a byte or queue the answer
    if (done) begin
      state_next.resp = ~word[rsurm_pkg::FRAME_RW_BIT];
      if (word[rsurm_pkg::FRAME_RW_BIT]) begin
        if (hit[4]) begin
          if (addr[0]) begin
            state_next.cfg[hit[3:0]][15:8] = word[7:0];
          end else begin
            state_next.cfg[hit[3:0]][7:0] = word[7:0];
          end
        end else if (waddr == rsurm_pkg::ADDR_SLEEP) begin
          if (addr[0]) begin
            state_next.sleep_value[15:8] = word[7:0];
          end else begin
            state_next.sleep_value[7:0] = word[7:0];
          end
          state_next.sleep_strobe = 1'b1;
        end else if (waddr == rsurm_pkg::ADDR_COMMAND) begin
          if (addr[0]) begin
            state_next.command_value[15:8] = word[7:0];
          end else begin
            state_next.command_value[7:0] = word[7:0];
          end
          state_next.command_strobe = 1'b1;
        end
      end else begin
        state_next.tx = rd_word;
      end
    end

    // a new sample wins over a read in the same cycle
    if (sample_load) begin
      state_next.samp = sample_in;
    end
    state_next.unread = (state_reg.unread & ~(done &&
      !word[rsurm_pkg::FRAME_RW_BIT] ? clr : '0)) |
      (sample_load ? rsurm_pkg::UNREAD_ALL : '0);

    // reload of flash-backed words right after reset
    if (state_reg.restore) begin
      state_next.restore = 1'b0;
      for (int i = 0; i < rsurm_pkg::CFG_N; i++) begin
        if (rsurm_pkg::CFG_NV_MASK[i]) begin
          state_next.cfg[i] = nv_image.cfg[i];
        end
      end
      state_next.sleep_value = nv_image.sleep_request;
      state_next.nv_write_count = nv_image.nv_write_count;
      state_next.lot_code_first = nv_image.lot_code_first;
      state_next.lot_code_second = nv_image.lot_code_second;
      state_next.unit_serial = nv_image.unit_serial;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.sclk_m <= 1'b1;
      state_reg.sclk_s <= 1'b1;
      state_reg.sclk_d <= 1'b1;
      state_reg.cs_m <= 1'b1;
      state_reg.cs_s <= 1'b1;
      state_reg.cfg <= rsurm_pkg::CFG_RESET;
      state_reg.unread <= rsurm_pkg::UNREAD_RESET;
      state_reg.restore <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dout = state_reg.dout;
  assign dout_oe = state_reg.dout_oe;
  assign cfg = rsurm_pkg::rsurm_cfg_type'(state_reg.cfg);
  assign sleep_value = state_reg.sleep_value;
  assign sleep_strobe = state_reg.sleep_strobe;
  assign command_value = state_reg.command_value;
  assign command_strobe = state_reg.command_strobe;

endmodule // rsurm_regmap

// ---- dv/rsurm_regmap_monitor.sv ----
// assertion checker for the register bank ports
`timescale 1ns/1ps
module rsurm_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dout,
  input wire logic dout_oe,
  // core side
  input wire rsurm_pkg::rsurm_cfg_type cfg,
  input wire logic sleep_strobe,
  input wire logic command_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a frame closes while the link clock is high and the chip selected
  sequence s_frame_end;
    sclk && !cs_n;
  endsequence
  sequence s_pulse_end(x);
    s_frame_end ##1 !x;
  endsequence
  chk_sleep_pulse: assert property (
    sleep_strobe |-> s_pulse_end(sleep_strobe))
    else $error("sleep strobe outside a frame end");
  chk_cmd_pulse: assert property (
    command_strobe |-> s_pulse_end(command_strobe))
    else $error("command strobe outside a frame end");
  chk_oe_idle: assert property (cs_n [*6] |-> !dout_oe)
    else $error("output driven while deselected");
  chk_oe_select: assert property ($rose(dout_oe) |-> !cs_n)
    else $error("output enabled without chip select");
  chk_dout_hold: assert property (
    $rose(sclk) && dout_oe && $past(dout_oe)
    |-> $stable(dout) ##1 $stable(dout))
    else $error("output moved at a link clock rise");
  chk_rst_quiet: assert property ($rose(rst_n) |->
    !dout_oe && !dout && !sleep_strobe && !command_strobe)
    else $error("outputs active after reset");
  chk_rst_cfg: assert property ($rose(rst_n) |->
    cfg.rate_gain_trim == 16'h0800 && cfg.misc_control == 16'h0006
    && cfg.range_and_filter == 16'h0401)
    else $error("configuration reset value wrong");
  chk_rst_volatile: assert property ($rose(rst_n) |-> ##2
    cfg.analog_out_setting == 16'h0000
    && cfg.dio_line_control == 16'h0000)
    else $error("volatile word restored from copy");
endmodule // rsurm_monitor
bind rsurm_regmap rsurm_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .cfg(cfg),
  .sleep_strobe(sleep_strobe), .command_strobe(command_strobe));

// ---- dv/rsurm_spi_master.sv ----
// serial link master model, clock idle high, msb first
`timescale 1ns/1ps
module rsurm_spi_master (
  // clock
  input wire logic clk,
  // link
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic [15:0] rx;
  logic oe_seen;
  event done;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge clk);
  endtask
  // one 16-bit frame; data out on the fall, taken on the rise
  task automatic xfer(input logic [15:0] tx);
    cs_n <= 1'b0;
    half();
    // cleared only after the bench has taken the previous frame's result
    oe_seen = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      din <= tx[i];
      half();
      sclk <= 1'b1;
      rx[i] = dout_oe ? dout : 1'b0;
      oe_seen = oe_seen | dout_oe;
      half();
    end
    cs_n <= 1'b1;
    din <= ~tx[0];
    half();
    -> done;
  endtask
endmodule // rsurm_spi_master

// ---- dv/rsurm_regmap_tb_top.sv ----
// self-checking bench of the register bank
`timescale 1ns/1ps
module rsurm_regmap_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_load = 1'b0;
  rsurm_pkg::rsurm_sample_type smp = '0;
  logic [15:0] err = 16'h0000;
  rsurm_pkg::rsurm_nv_type nv = '0;
  rsurm_pkg::rsurm_cfg_type cfg;
  logic [11:0][15:0] cw;
  logic [11:0][15:0] mdl;
  logic sclk, cs_n, din, dout, dout_oe, slp_s, cmd_s;
  logic [15:0] slp_v, cmd_v, w;
  logic [6:0] a;
  logic [16:0] expq[$];
  logic [16:0] pend = 17'h00000;
  int errors = 0;
  int checked = 0;
  int n_str = 0;
  int s;
  always #2 clk = ~clk;
  assign cw = cfg;
  always @(posedge clk) if (slp_s || cmd_s) n_str <= n_str + 1;
  rsurm_spi_master m (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe));
  rsurm_regmap dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe(dout_oe), .sample_load(sample_load),
    .sample_in(smp), .error_flags_in(err), .nv_image(nv), .cfg(cfg),
    .sleep_value(slp_v), .sleep_strobe(slp_s), .command_value(cmd_v),
    .command_strobe(cmd_s));
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    cmp({1'b0, got}, {1'b0, exp});
  endtask
  task automatic wrap_up();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // each frame carries the answer noted by the frame before it
  always @(m.done) cmp({m.oe_seen, m.rx}, expq.pop_front());
  task automatic frame(input logic [15:0] tx, input logic [16:0] nxt);
    expq.push_back(pend);
    pend = nxt;
    m.xfer(tx);
  endtask
  task automatic rd(input logic [6:0] ad, input logic [15:0] v);
    frame({1'b0, ad, 8'h00}, {1'b1, v});
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    frame({1'b1, ad, d}, 17'h00000);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    pend = 17'h00000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      mdl[i] = rsurm_pkg::CFG_NV_MASK[i] ? nv.cfg[i]
                                         : rsurm_pkg::CFG_RESET[i];
      cmp_reg(cw[i], mdl[i]);
    end
  endtask
  task automatic load(input logic [15:0] e);
    err <= e;
    smp <= {$urandom, $urandom, 2'b01};
    sample_load <= 1'b1;
    @(posedge clk);
    sample_load <= 1'b0;
    @(posedge clk);
  endtask
  task automatic outs(input logic f);
    rd(rsurm_pkg::ADDR_SUPPLY, {1'b1, f, 2'b00, smp.supply});
    rd(rsurm_pkg::ADDR_RATE, {1'b1, f, smp.rate});
    rd(rsurm_pkg::ADDR_RATE, {1'b0, f, smp.rate});
    rd(rsurm_pkg::ADDR_AUX, {1'b1, f, 2'b00, smp.aux});
    rd(rsurm_pkg::ADDR_TEMP, {1'b1, f, 2'b00, smp.temp});
    rd(rsurm_pkg::ADDR_RATE_EXT,
       smp.rate_ext & ~(16'hFFFF >> mdl[10][3:0]));
    rd(rsurm_pkg::ADDR_ERROR, err);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    wrap_up();
  end
  initial begin
    s = $urandom(32'h728BA160);
    repeat (9) nv = {nv[239:0], $urandom};
    do_reset();
    for (int i = 0; i < 12; i++) begin
      w = 16'($urandom);
      wr(rsurm_pkg::CFG_OFFS[i], w[7:0]);
      wr(rsurm_pkg::CFG_OFFS[i] + 7'h01, w[15:8]);
      mdl[i] = w;
      cmp_reg(cw[i], w);
    end
    for (int i = 0; i < 12; i++)
      rd(rsurm_pkg::CFG_OFFS[i] | 7'(i % 2), mdl[i]);
    rd(rsurm_pkg::ADDR_NV_WRITE_COUNT, nv.nv_write_count);
    rd(rsurm_pkg::ADDR_LOT1, nv.lot_code_first);
    rd(rsurm_pkg::ADDR_LOT2, nv.lot_code_second);
    rd(rsurm_pkg::ADDR_SERIAL, nv.unit_serial);
    rd(rsurm_pkg::ADDR_PART, rsurm_pkg::PART_CODE_DEFAULT);
    wr(7'h08, 8'hA5);
    rd(7'h09, 16'h0000);
    load(16'h0000);
    outs(1'b0);
    load(16'($urandom) | 16'h0001);
    outs(1'b1);
    for (int k = 0; k < 2; k++) begin
      w = 16'($urandom);
      a = k ? rsurm_pkg::ADDR_COMMAND : rsurm_pkg::ADDR_SLEEP;
      wr(a, w[7:0]);
      wr(a + 7'h01, w[15:8]);
      rd(a, 16'h0000);
      cmp_reg(k ? cmd_v : slp_v, w);
    end
    cmp_reg(16'(n_str), 16'h0004);
    do_reset();
    rd(rsurm_pkg::CFG_OFFS[11], mdl[11]);
    wr(7'h08, 8'h00);
    // let the answer checker take the last frame before the verdict
    @(posedge clk);
    wrap_up();
  end
endmodule // rsurm_regmap_tb_top
